// file: design/byteswap_xor_shadow_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "byteswap_consts.svh"
module byteswap_xor_shadow_decode (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr,
  input  wire logic [2:0]  arch_release,
  input  wire logic [3:0]  cop_usable,
  input  wire logic [3:0]  previous_shadow_set,
  input  wire logic [31:0] src_a_data,
  input  wire logic [31:0] src_b_data,
  output logic      [4:0]  src_a_addr,
  output logic      [4:0]  src_b_addr,
  output logic             retire_r,
  output logic             gpr_we_r,
  output logic             shadow_we_r,
  output logic      [4:0]  wr_addr_r,
  output logic      [3:0]  shadow_set_r,
  output logic      [31:0] wr_data_r,
  output logic             exc_ri_r,
  output logic             exc_cpu_r,
  output logic      [1:0]  exc_cop_r
);
  import byteswap_pkg::*;

  decode_if dbus ();

  wire logic [31:0] alu_result;
  wire logic        exc_any;
  wire logic        gpr_op;
  wire logic        shadow_op;
  wire logic [4:0]  dest_addr;
  wire logic        retire_nxt;
  wire logic        gpr_we_nxt;
  wire logic        shadow_we_nxt;
  wire logic        exc_ri_nxt;
  wire logic        exc_cpu_nxt;

  op_decoder u_dec (
    .instr        (instr),
    .arch_release (arch_release),
    .cop_usable   (cop_usable),
    .dec          (dbus)
  );

  logic_unit u_alu (
    .dec    (dbus),
    .src_a  (src_a_data),
    .src_b  (src_b_data),
    .imm    (instr[`F_IMM]),
    .result (alu_result)
  );

  // operand reads are combinational so the register files answer in the same cycle
  assign src_a_addr = instr[`F_RS];
  assign src_b_addr = instr[`F_RT];

  assign exc_any = dbus.ri | dbus.cpu;
  assign gpr_op = (dbus.op == OP_XOR) || (dbus.op == OP_XOR_WITH_IMMEDIATE) || (dbus.op == OP_WSBH);
  assign shadow_op = (dbus.op == OP_WRITE_PREVIOUS_SHADOW_REG);
  // immediate xor targets the second source field, the rest the destination field
  assign dest_addr = (dbus.op == OP_XOR_WITH_IMMEDIATE) ? instr[`F_RT] : instr[`F_RD];

  assign retire_nxt = instr_valid;
  assign gpr_we_nxt = instr_valid && gpr_op && !exc_any;
  assign shadow_we_nxt = instr_valid && shadow_op && !exc_any;
  assign exc_ri_nxt = instr_valid && dbus.ri;
  assign exc_cpu_nxt = instr_valid && dbus.cpu;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      retire_r     <= 1'b0;
      gpr_we_r     <= 1'b0;
      shadow_we_r  <= 1'b0;
      exc_ri_r     <= 1'b0;
      exc_cpu_r    <= 1'b0;
    end else begin
      retire_r     <= retire_nxt;
      gpr_we_r     <= gpr_we_nxt;
      shadow_we_r  <= shadow_we_nxt;
      exc_ri_r     <= exc_ri_nxt;
      exc_cpu_r    <= exc_cpu_nxt;
    end
  end

  // data side only moves on a valid slot, so it holds the last result for debug
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_addr_r    <= 5'h00;
      shadow_set_r <= 4'h0;
      wr_data_r    <= 32'h0000_0000;
      exc_cop_r    <= 2'h0;
    end else if (instr_valid) begin
      wr_addr_r    <= dest_addr;
      shadow_set_r <= previous_shadow_set;
      wr_data_r    <= alu_result;
      exc_cop_r    <= dbus.cop_num;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  wire logic in_xor;
  wire logic in_xor_with_immediate;
  wire logic in_wsbh;
  wire logic in_write_previous_shadow_reg;
  wire logic early_rel;

  assign in_xor = (instr[31:26] == 6'h00) && (instr[`F_FUNC] == `FUNC_XOR)
                  && (instr[`F_SA] == `SA_ZERO);
  assign in_xor_with_immediate = (instr[`F_ROW] == `ROW_XOR_WITH_IMMEDIATE) && (instr[`F_COL] == `COL_XOR_WITH_IMMEDIATE);
  assign in_wsbh = (instr[`F_ROW] == `ROW_SPECIAL3) && (instr[`F_COL] == `COL_SPECIAL3)
                   && (instr[`F_FUNC] == `FUNC_BSHFL) && (instr[`F_SA] == `SA_WSBH)
                   && (instr[`F_RS] == `RS_ZERO);
  assign in_write_previous_shadow_reg = (instr[`F_ROW] == `ROW_COP) && (instr[`F_COL] == `COL_REGISTER_FUNCTION_CLASS)
                     && (instr[`F_RS] == `RS_WRITE_PREVIOUS_SHADOW_REG) && (instr[`F_SA] == `SA_ZERO)
                     && (instr[`F_FUNC] == `FUNC_ZERO);
  assign early_rel = (arch_release < `REL_SHADOW);

  sequence s_issue_xor;
    instr_valid && in_xor;
  endsequence

  sequence s_retire_gpr;
    retire_r && gpr_we_r && !exc_ri_r && !exc_cpu_r;
  endsequence

  sequence s_retire_fault_ri;
    retire_r && exc_ri_r && !exc_cpu_r && !gpr_we_r && !shadow_we_r;
  endsequence

  chk_early_rel_swap: assert property (
    instr_valid && in_wsbh && early_rel |=> s_retire_fault_ri)
    else $error("byte swap executed before release 2");

  chk_early_rel_shadow: assert property (
    instr_valid && in_write_previous_shadow_reg && early_rel && cop_usable[0] |=> s_retire_fault_ri)
    else $error("shadow write executed before release 2");

  chk_shadow_write_path: assert property (
    instr_valid && in_write_previous_shadow_reg && !early_rel && cop_usable[0]
    |=> shadow_we_r && !gpr_we_r && (wr_data_r == $past(src_b_data))
        && (wr_addr_r == $past(instr[`F_RD]))
        && (shadow_set_r == $past(previous_shadow_set)))
    else $error("shadow write lost its data, address or set");

  chk_shadow_cpu_block: assert property (
    instr_valid && in_write_previous_shadow_reg && !cop_usable[0]
    |=> exc_cpu_r && !exc_ri_r && !shadow_we_r && (exc_cop_r == 2'h0))
    else $error("shadow write not blocked by unusable coprocessor");

  chk_swap_lanes: assert property (
    instr_valid && in_wsbh && !early_rel
    |=> s_retire_gpr ##0 (wr_data_r == {$past(src_b_data[23:16]), $past(src_b_data[31:24]),
                                        $past(src_b_data[7:0]), $past(src_b_data[15:8])}))
    else $error("byte swap lanes wrong");

  chk_xor_decode: assert property (
    s_issue_xor |=> s_retire_gpr ##0 (wr_addr_r == $past(instr[`F_RD])))
    else $error("register xor not recognised");

  chk_xor_sa_nonzero: assert property (
    instr_valid && (instr[31:26] == 6'h00) && (instr[`F_FUNC] == `FUNC_XOR)
    && (instr[`F_SA] != `SA_ZERO) |=> s_retire_fault_ri)
    else $error("xor with nonzero shift field accepted");

  chk_xor_value: assert property (
    s_issue_xor |=> wr_data_r == ($past(src_a_data) ^ $past(src_b_data)))
    else $error("register xor value wrong");

  chk_xor_with_immediate_value: assert property (
    instr_valid && in_xor_with_immediate
    |=> s_retire_gpr ##0 (wr_addr_r == $past(instr[`F_RT]))
        ##0 (wr_data_r == ($past(src_a_data) ^ {16'h0000, $past(instr[`F_IMM])})))
    else $error("immediate xor value or target wrong");

  chk_register_immediate_class_resolved: assert property (
    instr_valid && (instr[`F_ROW] == `ROW_REGISTER_FUNCTION_CLASS) && (instr[`F_COL] == `COL_REGISTER_IMMEDIATE_CLASS)
    |=> s_retire_fault_ri)
    else $error("register-immediate class treated as complete instruction");

  chk_reserved_row: assert property (
    instr_valid && (instr[`F_ROW] > `ROW_SPECIAL3) |=> s_retire_fault_ri)
    else $error("unused primary row not reserved");

  chk_cop_priority: assert property (
    instr_valid && (instr[`F_ROW] == `ROW_COP) && !instr[28] && !cop_usable[instr[27:26]]
    && (instr[27:26] != `COL_COP1X) |=> exc_cpu_r && !exc_ri_r)
    else $error("coprocessor unusable lost priority");

  chk_newer_code: assert property (
    instr_valid && early_rel && (in_wsbh || (in_write_previous_shadow_reg && cop_usable[0]))
    |=> !gpr_we_r && !shadow_we_r ##1 1'b1)
    else $error("newer revision code executed");

  chk_fault_no_write: assert property (
    exc_ri_r || exc_cpu_r |-> !gpr_we_r && !shadow_we_r)
    else $error("write issued alongside an exception");

  chk_idle_quiet: assert property (
    !instr_valid |=> !retire_r && !gpr_we_r && !shadow_we_r && !exc_ri_r && !exc_cpu_r)
    else $error("activity without a valid slot");

  chk_one_cycle: assert property (
    instr_valid |=> retire_r && (gpr_we_r || shadow_we_r || exc_ri_r || exc_cpu_r))
    else $error("valid slot did not complete in one cycle");
endmodule // byteswap_xor_shadow_decode
`default_nettype wire

// file: design/byteswap_consts.svh
`ifndef BYTESWAP_CONSTS_SVH
`define BYTESWAP_CONSTS_SVH
// instruction field slices
`define F_ROW   31:29
`define F_COL   28:26
`define F_RS    25:21
`define F_RT    20:16
`define F_RD    15:11
`define F_SA    10:6
`define F_FUNC  5:0
`define F_IMM   15:0
// primary table positions, row then column
`define ROW_REGISTER_FUNCTION_CLASS   3'h0
`define COL_REGISTER_FUNCTION_CLASS   3'h0
`define COL_REGISTER_IMMEDIATE_CLASS    3'h1
`define ROW_XOR_WITH_IMMEDIATE      3'h1
`define COL_XOR_WITH_IMMEDIATE      3'h6
`define ROW_COP       3'h2
`define ROW_SPECIAL3  3'h3
`define COL_SPECIAL3  3'h7
`define COL_COP1X     2'h3
`define COP_ONE       2'h1
// secondary field codes
`define FUNC_XOR      6'h26
`define FUNC_BSHFL    6'h20
`define FUNC_ZERO     6'h00
`define SA_ZERO       5'h00
`define SA_WSBH       5'h02
`define RS_ZERO       5'h00
`define RS_WRITE_PREVIOUS_SHADOW_REG     5'h0e
// first architecture release that has the shadow write and byte swap
`define REL_SHADOW    3'h2
// byte lane geometry
`define BYTE_W        8
`define HALF_W        16
`endif

// file: design/byteswap_pkg.sv
package byteswap_pkg;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_XOR,
    OP_XOR_WITH_IMMEDIATE,
    OP_WSBH,
    OP_WRITE_PREVIOUS_SHADOW_REG
  } op_type;
  typedef enum logic [2:0] {
    CLS_RSVD,
    CLS_REGISTER_FUNCTION_CLASS,
    CLS_REGISTER_IMMEDIATE_CLASS,
    CLS_XOR_WITH_IMMEDIATE,
    CLS_COP,
    CLS_SPECIAL3
  } class_type;
endpackage

// file: design/decode_if.sv
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
  import byteswap_pkg::*;
  op_type     op;
  logic       ri;
  logic       cpu;
  logic [1:0] cop_num;
  modport dec (output op, output ri, output cpu, output cop_num);
  modport sink (input op, input ri, input cpu, input cop_num);
endinterface
`default_nettype wire

// file: design/op_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "byteswap_consts.svh"
module op_decoder (
  input  wire logic [31:0] instr,
  input  wire logic [2:0]  arch_release,
  input  wire logic [3:0]  cop_usable,
  decode_if.dec            dec
);
  import byteswap_pkg::*;

  function automatic class_type primary_class(input logic [2:0] row, input logic [2:0] col);
    class_type c;
    c = CLS_RSVD;
    case (row)
      `ROW_REGISTER_FUNCTION_CLASS: begin
        if (col == `COL_REGISTER_FUNCTION_CLASS) c = CLS_REGISTER_FUNCTION_CLASS;
        else if (col == `COL_REGISTER_IMMEDIATE_CLASS) c = CLS_REGISTER_IMMEDIATE_CLASS;
      end
      `ROW_XOR_WITH_IMMEDIATE:     c = (col == `COL_XOR_WITH_IMMEDIATE) ? CLS_XOR_WITH_IMMEDIATE : CLS_RSVD;
      `ROW_COP:      c = (col[2] == 1'b0) ? CLS_COP : CLS_RSVD;
      `ROW_SPECIAL3: c = (col == `COL_SPECIAL3) ? CLS_SPECIAL3 : CLS_RSVD;
      default:       c = CLS_RSVD;
    endcase
    return c;
  endfunction

  class_type  cls;
  wire logic  rel_ok;
  wire logic  is_xor;
  wire logic  is_xor_with_immediate;
  wire logic  is_wsbh;
  wire logic  is_write_previous_shadow_reg;
  wire logic  known;
  wire logic  cop_block;
  wire logic [1:0] cop_idx;

  assign cls = primary_class(instr[`F_ROW], instr[`F_COL]);
  assign rel_ok = (arch_release >= `REL_SHADOW);
  // class entries resolved through their own field
  assign is_xor = (cls == CLS_REGISTER_FUNCTION_CLASS) && (instr[`F_FUNC] == `FUNC_XOR)
                  && (instr[`F_SA] == `SA_ZERO);
  assign is_xor_with_immediate = (cls == CLS_XOR_WITH_IMMEDIATE);
  assign is_wsbh = (cls == CLS_SPECIAL3) && (instr[`F_FUNC] == `FUNC_BSHFL)
                   && (instr[`F_SA] == `SA_WSBH) && (instr[`F_RS] == `RS_ZERO);
  assign is_write_previous_shadow_reg = (cls == CLS_COP) && (instr[`F_COL] == `COL_REGISTER_FUNCTION_CLASS)
                     && (instr[`F_RS] == `RS_WRITE_PREVIOUS_SHADOW_REG) && (instr[`F_SA] == `SA_ZERO)
                     && (instr[`F_FUNC] == `FUNC_ZERO);
  // register-immediate members live in another unit, so here they fall to reserved
  assign known = is_xor | is_xor_with_immediate | ((is_wsbh | is_write_previous_shadow_reg) & rel_ok);
  assign cop_idx = (instr[`F_COL] == {1'b0, `COL_COP1X}) ? `COP_ONE : instr[27:26];
  assign cop_block = (cls == CLS_COP) && !cop_usable[cop_idx];

  assign dec.cpu = cop_block;
  assign dec.ri = !cop_block && !known;
  assign dec.cop_num = cop_idx;
  assign dec.op = !known    ? OP_NONE :
                  is_xor    ? OP_XOR :
                  is_xor_with_immediate   ? OP_XOR_WITH_IMMEDIATE :
                  is_wsbh   ? OP_WSBH : OP_WRITE_PREVIOUS_SHADOW_REG;
endmodule // op_decoder
`default_nettype wire

// file: design/logic_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "byteswap_consts.svh"
module logic_unit (
  decode_if.sink             dec,
  input  wire logic [31:0]   src_a,
  input  wire logic [31:0]   src_b,
  input  wire logic [15:0]   imm,
  output logic      [31:0]   result
);
  import byteswap_pkg::*;

  wire logic [31:0] swapped;
  wire logic [31:0] imm_ext;

  genvar h;
  generate
    for (h = 0; h < 2; h++) begin : g_half
      assign swapped[h*`HALF_W +: `BYTE_W] = src_b[h*`HALF_W+`BYTE_W +: `BYTE_W];
      assign swapped[h*`HALF_W+`BYTE_W +: `BYTE_W] = src_b[h*`HALF_W +: `BYTE_W];
    end
  endgenerate

  assign imm_ext = {{`HALF_W{1'b0}}, imm};

  always_comb begin
    case (dec.op)
      OP_XOR:    result = src_a ^ src_b;
      OP_XOR_WITH_IMMEDIATE:   result = src_a ^ imm_ext;
      OP_WSBH:   result = swapped;
      OP_WRITE_PREVIOUS_SHADOW_REG: result = src_b;
      default:   result = src_b;
    endcase
  end
endmodule // logic_unit
`default_nettype wire

// file: bench/regfile_model.sv
`timescale 1ns/1ps
`default_nettype none
// register files on the far side: combinational reads, writes on the pulse edge
module regfile_model (
  input  wire logic        mclk,
  input  wire logic [4:0]  src_a_addr,
  input  wire logic [4:0]  src_b_addr,
  output logic      [31:0] src_a_data,
  output logic      [31:0] src_b_data,
  input  wire logic        gpr_we,
  input  wire logic        shadow_we,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [3:0]  shadow_set,
  input  wire logic [31:0] wr_data
);
  logic [31:0] gpr [32];
  logic [31:0] shadow [16][32];
  initial begin
    // uneven byte pattern so a lane slip shows up
    for (int i = 0; i < 32; i++) begin
      gpr[i] = 32'h1357_9bdf + (32'h0102_0408 * 32'(i));
    end
  end
  // register zero always reads zero
  assign src_a_data = (src_a_addr == 5'h00) ? 32'h0000_0000 : gpr[src_a_addr];
  assign src_b_data = (src_b_addr == 5'h00) ? 32'h0000_0000 : gpr[src_b_addr];
  always @(posedge mclk) begin
    if (gpr_we) begin
      gpr[wr_addr] <= wr_data;
    end
    if (shadow_we) begin
      shadow[shadow_set][wr_addr] <= wr_data;
    end
  end
endmodule // regfile_model
`default_nettype wire

// file: bench/byteswap_xor_shadow_decode_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module byteswap_xor_shadow_decode_tb_top;
  import byteswap_pkg::*;
  localparam logic [4:0] FL_GPR = 5'h18;
  localparam logic [4:0] FL_SH  = 5'h14;
  localparam logic [4:0] FL_RI  = 5'h12;
  localparam logic [4:0] FL_CPU = 5'h11;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        instr_valid = 1'b0;
  logic [31:0] instr = 32'h0000_0000;
  logic [2:0]  arch_release = 3'h2;
  logic [3:0]  cop_usable = 4'h1;
  logic [3:0]  previous_shadow_set = 4'h0;
  logic [31:0] src_a_data, src_b_data, wr_data_r;
  logic [4:0]  src_a_addr, src_b_addr, wr_addr_r;
  logic        retire_r, gpr_we_r, shadow_we_r, exc_ri_r, exc_cpu_r;
  logic [3:0]  shadow_set_r;
  logic [1:0]  exc_cop_r;
  int          fails = 0;
  int          total_checks = 0;
  logic [31:0] a, b;

  always #12.5 mclk = ~mclk;

  byteswap_xor_shadow_decode DUT (
    .mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .arch_release(arch_release), .cop_usable(cop_usable),
    .previous_shadow_set(previous_shadow_set), .src_a_data(src_a_data),
    .src_b_data(src_b_data), .src_a_addr(src_a_addr), .src_b_addr(src_b_addr),
    .retire_r(retire_r), .gpr_we_r(gpr_we_r), .shadow_we_r(shadow_we_r),
    .wr_addr_r(wr_addr_r), .shadow_set_r(shadow_set_r), .wr_data_r(wr_data_r),
    .exc_ri_r(exc_ri_r), .exc_cpu_r(exc_cpu_r), .exc_cop_r(exc_cop_r)
  );

  regfile_model partner (
    .mclk(mclk), .src_a_addr(src_a_addr), .src_b_addr(src_b_addr),
    .src_a_data(src_a_data), .src_b_data(src_b_data), .gpr_we(gpr_we_r),
    .shadow_we(shadow_we_r), .wr_addr(wr_addr_r), .shadow_set(shadow_set_r),
    .wr_data(wr_data_r)
  );

  task automatic close_out();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // flags are {retire, gpr write, shadow write, reserved, unusable}
  task automatic cmp_flags(input logic [4:0] exp);
    logic [4:0] got;
    got = {retire_r, gpr_we_r, shadow_we_r, exc_ri_r, exc_cpu_r};
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: flags %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  // one instruction, answer looked at in its single answer cycle; the extra edge
  // lets the register write land before the next scenario reads the model
  task automatic issue(input logic [31:0] w, input logic [2:0] rel, input logic [3:0] cop,
                       input logic [4:0] exp);
    @(posedge mclk);
    instr_valid  <= 1'b1;
    instr        <= w;
    arch_release <= rel;
    cop_usable   <= cop;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    cmp_flags(exp);
    @(posedge mclk);
    #1;
  endtask

  task automatic t_xor();
    a = partner.gpr[3];
    b = partner.gpr[4];
    issue({6'h00, 5'h03, 5'h04, 5'h05, 5'h00, 6'h26}, 3'h2, 4'h1, FL_GPR);
    cmp_val(wr_data_r, a ^ b);
    cmp_val({27'h0, wr_addr_r}, 32'h0000_0005);
    issue({6'h00, 5'h03, 5'h04, 5'h05, 5'h01, 6'h26}, 3'h2, 4'h1, FL_RI);
    issue({6'h00, 5'h03, 5'h04, 5'h05, 5'h00, 6'h27}, 3'h2, 4'h1, FL_RI);
  endtask

  task automatic t_xor_with_immediate();
    a = partner.gpr[6];
    issue({6'h0e, 5'h06, 5'h07, 16'h8001}, 3'h2, 4'h1, FL_GPR);
    cmp_val(wr_data_r, a ^ 32'h0000_8001);
    cmp_val({27'h0, wr_addr_r}, 32'h0000_0007);
  endtask

  task automatic t_wsbh();
    b = partner.gpr[9];
    issue({6'h1f, 5'h00, 5'h09, 5'h0a, 5'h02, 6'h20}, 3'h2, 4'h1, FL_GPR);
    cmp_val(wr_data_r, {b[23:16], b[31:24], b[7:0], b[15:8]});
    issue({6'h1f, 5'h00, 5'h09, 5'h0a, 5'h02, 6'h20}, 3'h1, 4'h1, FL_RI);
    issue({6'h1f, 5'h01, 5'h09, 5'h0a, 5'h02, 6'h20}, 3'h2, 4'h1, FL_RI);
  endtask

  task automatic t_shadow();
    @(posedge mclk);
    previous_shadow_set <= 4'h9;
    b = partner.gpr[12];
    issue({6'h10, 5'h0e, 5'h0c, 5'h0d, 11'h000}, 3'h2, 4'h1, FL_SH);
    cmp_val(wr_data_r, b);
    cmp_val({27'h0, wr_addr_r}, 32'h0000_000d);
    cmp_val({28'h0, shadow_set_r}, 32'h0000_0009);
    cmp_val(partner.shadow[9][13], b);
    issue({6'h10, 5'h0e, 5'h0c, 5'h0d, 11'h000}, 3'h2, 4'h0, FL_CPU);
    cmp_val({30'h0, exc_cop_r}, 32'h0000_0000);
    issue({6'h10, 5'h0e, 5'h0c, 5'h0d, 11'h000}, 3'h1, 4'h1, FL_RI);
  endtask

  task automatic t_reserved();
    issue({6'h01, 5'h02, 5'h00, 16'h0010}, 3'h2, 4'h1, FL_RI);
    issue(32'hfc00_0000, 3'h2, 4'hf, FL_RI);
    issue({6'h11, 26'h000_0000}, 3'h2, 4'hf, FL_RI);
    issue({6'h11, 26'h000_0000}, 3'h2, 4'h1, FL_CPU);
    cmp_val({30'h0, exc_cop_r}, 32'h0000_0001);
    issue({6'h10, 5'h00, 21'h00_0000}, 3'h2, 4'h0, FL_CPU);
    cmp_val({30'h0, exc_cop_r}, 32'h0000_0000);
    issue({6'h13, 26'h000_0000}, 3'h2, 4'h1, FL_CPU);
    cmp_val({30'h0, exc_cop_r}, 32'h0000_0001);
    issue({6'h10, 5'h00, 21'h00_0000}, 3'h2, 4'h1, FL_RI);
  endtask

  task automatic t_back2back();
    a = partner.gpr[3];
    b = partner.gpr[4];
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr       <= {6'h00, 5'h03, 5'h04, 5'h0e, 5'h00, 6'h26};
    @(posedge mclk);
    instr <= {6'h0e, 5'h06, 5'h0f, 16'hffff};
    #1;
    cmp_flags(FL_GPR);
    cmp_val(wr_data_r, a ^ b);
    a = partner.gpr[6];
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    cmp_flags(FL_GPR);
    cmp_val(wr_data_r, a ^ 32'h0000_ffff);
    cmp_val({27'h0, wr_addr_r}, 32'h0000_000f);
    @(posedge mclk);
    #1;
    cmp_flags(5'h00);
  endtask

  initial begin
    repeat (3000) @(posedge mclk);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    cmp_flags(5'h00);
    cmp_val(wr_data_r, 32'h0000_0000);
    t_xor();
    t_xor_with_immediate();
    t_wsbh();
    t_shadow();
    t_reserved();
    t_back2back();
    close_out();
  end
endmodule // byteswap_xor_shadow_decode_tb_top
`default_nettype wire
